// ===== core/elp_pkg.sv
// Package of constants for the EEPROM load and interrupt pin logic.
// Notes on behaviour
// - In master mode a low load request starts the configuration read from the external EEPROM.
// - After a finished load the request may stay low and the load is not restarted.
// - In master mode the done output stays high until a load has completed successfully, then goes low.
// - In slave mode a low load request holds the bus state machine and the registers in reset.
// - In slave mode the done output follows the level on the load request input.
// - The interrupt output is active low and pulls low while an enabled interrupt event is pending.
// - Software selects through management registers which events may raise the interrupt.
// - The interrupt output is open drain and may share a wired-OR line with one pull-up.
// - Outside factory test mode the reserved test pins are inputs whose level is ignored.
package elp_pkg;

    // Strap codes of the four-level role selection.
    localparam logic [1:0] ELP_ROLE_TEST_LO  = 2'h0;
    localparam logic [1:0] ELP_ROLE_TEST_R   = 2'h1;
    localparam logic [1:0] ELP_ROLE_MASTER   = 2'h2;
    localparam logic [1:0] ELP_ROLE_SLAVE    = 2'h3;

    // Default number of interrupt event sources.
    localparam int ELP_EVENTS_DEFAULT = 8;

    // Load sequencer states, one-hot.
    typedef enum logic [3:0] {
        ELP_IDLE = 4'h1,
        ELP_LOAD = 4'h2,
        ELP_DONE = 4'h4,
        ELP_FAIL = 4'h8
    } elp_state_e;

endpackage : elp_pkg

// ===== core/elp_irq_gate.sv
// Masked, sticky interrupt gate driving an open-drain active-low pin.
`timescale 1ns/10ps
`default_nettype none
module elp_irq_gate #(
    parameter int EVENTS = 8
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              clear_all,
    // Events and software control
    input  wire logic [EVENTS-1:0] event_pulse,
    input  wire logic [EVENTS-1:0] event_enable,
    input  wire logic [EVENTS-1:0] event_clear,
    output logic [EVENTS-1:0]      event_pending,
    // Open-drain pin
    output logic                   irq_n_out,
    output logic                   irq_n_oe
);

    initial begin
        if (EVENTS < 1) $error("EVENTS must be at least one");
    end

    typedef struct packed {
        logic [EVENTS-1:0] pend;
        logic              drive;
    } elp_irq_s;

    elp_irq_s st_reg;
    elp_irq_s st_next;

    // A new event wins over event_clear in the same cycle; clear_all still drops it.
    always_comb begin
        st_next       = st_reg;
        st_next.pend  = (st_reg.pend & ~event_clear) | event_pulse;
        if (clear_all) begin
            st_next.pend = '0;
        end
        st_next.drive = |(st_next.pend & event_enable);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Only ever drives low; the line level comes from the shared pull-up.
    assign irq_n_out     = 1'b0;
    assign irq_n_oe      = st_reg.drive;
    assign event_pending = st_reg.pend;

endmodule : elp_irq_gate
`default_nettype wire

// ===== core/elp_top.sv
// Load request, completion indication, interrupt pin and test pin handling.
`timescale 1ns/10ps
`default_nettype none
module elp_top
    import elp_pkg::*;
#(
    parameter int EVENTS = ELP_EVENTS_DEFAULT
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Role strap, decoded four-level code
    input  wire logic [1:0]        bus_role_select,
    // Load request pin and completion pin
    input  wire logic              load_req_n,
    output logic                   all_done_n,
    // EEPROM load engine handshake
    output logic                   load_start,
    input  wire logic              load_finished,
    input  wire logic              load_ok,
    // Reset to bus state machine and registers in slave mode
    output logic                   mgmt_reset,
    // Interrupt events and register-side control
    input  wire logic [EVENTS-1:0] event_pulse,
    input  wire logic [EVENTS-1:0] event_enable,
    input  wire logic [EVENTS-1:0] event_clear,
    output logic [EVENTS-1:0]      event_pending,
    // Open-drain interrupt pin
    output logic                   irq_n_out,
    output logic                   irq_n_oe,
    // Reserved factory test inputs
    input  wire logic              factory_test_in_a,
    input  wire logic              factory_test_in_b,
    input  wire logic              factory_test_in_c,
    input  wire logic              factory_test_in_d,
    input  wire logic              factory_test_in_e,
    input  wire logic              factory_test_in_f
);

    typedef struct packed {
        elp_state_e state;
        logic       done_n;
        logic       start;
        logic       mreset;
    } elp_top_s;

    elp_top_s st_reg;
    elp_top_s st_next;

    logic is_master;
    logic is_slave;
    logic test_unused;

    // Role decode; the two test codes run neither mode.
    assign is_master = (bus_role_select == ELP_ROLE_MASTER);
    assign is_slave  = (bus_role_select == ELP_ROLE_SLAVE);

    // Test pins have no effect on any logic outside factory test.
    assign test_unused = factory_test_in_a ^ factory_test_in_b ^ factory_test_in_c
                       ^ factory_test_in_d ^ factory_test_in_e ^ factory_test_in_f;

    // Sequencer: a low request starts one load; done is reported once only
    // a successful finish is seen, and holding the request low afterwards
    // is simply normal operation.
    always_comb begin
        st_next        = st_reg;
        st_next.start  = 1'b0;
        st_next.mreset = is_slave && !load_req_n;
        if (is_slave) begin
            st_next.state  = ELP_IDLE;
            st_next.done_n = load_req_n;
        end else if (!is_master) begin
            st_next.state  = ELP_IDLE;
            st_next.done_n = 1'b1;
        end else begin
            unique case (st_reg.state)
                ELP_IDLE: begin
                    st_next.done_n = 1'b1;
                    if (!load_req_n) begin
                        st_next.state = ELP_LOAD;
                        st_next.start = 1'b1;
                    end
                end
                ELP_LOAD: begin
                    st_next.done_n = 1'b1;
                    if (load_req_n) begin
                        st_next.state = ELP_IDLE;
                    end else if (load_finished) begin
                        st_next.state  = load_ok ? ELP_DONE : ELP_FAIL;
                        st_next.done_n = !load_ok;
                    end
                end
                ELP_DONE: begin
                    st_next.done_n = 1'b0;
                end
                ELP_FAIL: begin
                    // A failed load stays failed until the request is released.
                    st_next.done_n = 1'b1;
                    if (load_req_n) begin
                        st_next.state = ELP_IDLE;
                    end
                end
                default: begin
                    st_next.state  = ELP_IDLE;
                    st_next.done_n = 1'b1;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= '{state: ELP_IDLE, done_n: 1'b1, start: 1'b0, mreset: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign all_done_n = st_reg.done_n;
    assign load_start = st_reg.start;
    assign mgmt_reset = st_reg.mreset;

    // Interrupt gate; slave-mode reset also clears pending events.
    elp_irq_gate #(
        .EVENTS(EVENTS)
    ) u_irq (
        .clock        (clock),
        .rst          (rst),
        .clear_all    (st_reg.mreset | (test_unused & 1'b0)),
        .event_pulse  (event_pulse),
        .event_enable (event_enable),
        .event_clear  (event_clear),
        .event_pending(event_pending),
        .irq_n_out    (irq_n_out),
        .irq_n_oe     (irq_n_oe)
    );

endmodule : elp_top
`default_nettype wire

// ===== verification/elp_assertions.sv
// Checker for the load, completion and interrupt pin behaviour of elp_top.
`timescale 1ns/10ps
`default_nettype none
module elp_assertions #(parameter int EVENTS = 8) (
    // Clock, reset, strap, load handshake and interrupt pin.
    input wire logic [1:0]        bus_role_select,
    input wire logic              clock, rst, load_req_n, all_done_n, load_start,
    input wire logic              load_finished, load_ok, mgmt_reset, irq_n_out, irq_n_oe,
    // Interrupt events.
    input wire logic [EVENTS-1:0] event_pulse, event_enable, event_clear, event_pending
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Role decode; the strap is static outside reset.
    wire slv = bus_role_select == 2'h3;
    wire mst = bus_role_select == 2'h2;
    a_slave_done_follow: assert property (slv |=> all_done_n == $past(load_req_n))
        else $error("done not following request");
    a_slave_reset_hold: assert property (slv |=> mgmt_reset != $past(load_req_n))
        else $error("slave reset wrong");
    a_master_no_reset: assert property (!slv |=> !mgmt_reset) else $error("stray reset");
    a_start_one_cycle: assert property (load_start |=> !load_start) else $error("long start");
    a_start_needs_req: assert property (load_start |-> !$past(load_req_n) && mst)
        else $error("start without request");
    a_fail_keeps_high: assert property (mst && all_done_n && !(load_finished && load_ok)
        |=> all_done_n) else $error("done low without good load");
    a_done_stays_low: assert property (mst && !all_done_n |=> !all_done_n)
        else $error("done lost");
    a_irq_raise: assert property ((event_pulse & event_enable) != 0 && !mgmt_reset
        |=> irq_n_oe) else $error("irq not raised");
    a_irq_idle: assert property (event_pending == 0 && event_pulse == 0 |=> !irq_n_oe)
        else $error("irq without event");
    a_od_low: assert property (irq_n_out == 1'b0) else $error("irq pin not low");
    c_load: cover property (mst && $fell(all_done_n));
    c_slave: cover property (slv && mgmt_reset);
    c_irq: cover property ($rose(irq_n_oe));
endmodule // elp_assertions
bind elp_top elp_assertions #(.EVENTS(EVENTS)) u_chk (.*);
`default_nettype wire

// ===== verification/elp_eeprom_model.sv
// Behavioural EEPROM load engine that answers a start pulse after a delay.
`timescale 1ns/10ps
`default_nettype none
module elp_eeprom_model (
    // Clock, reset and scenario controls
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       load_start,
    input  wire logic       fail,
    input  wire logic [3:0] dly,
    // Answer to the design
    output logic            load_finished,
    output logic            load_ok
);
    logic [4:0] cnt;
    // Outside its valid cycle load_ok toggles, so a stale status is never mistaken for good.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 5'h00;
            load_finished <= 1'b0;
            load_ok <= 1'b0;
        end else begin
            load_finished <= cnt == 5'h01;
            load_ok <= (cnt == 5'h01) ? !fail : !load_ok;
            cnt <= load_start ? {1'b0, dly} + 5'h01 : cnt - {4'h0, cnt != 5'h00};
        end
    end
endmodule // elp_eeprom_model
`default_nettype wire

// ===== verification/elp_top_tb.sv
// Self-checking bench for the load request, completion and interrupt pin logic.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module elp_top_tb;
    logic        clock = 1'b0, rst = 1'b1, req_n = 1'b1, fail = 1'b0, fin, ok, start, mrst;
    logic        done_n, oe, od;
    logic [1:0]  role = 2'h2;
    logic [3:0]  dly = 4'h3;
    logic [4:0]  nst = 5'h00, starts = 5'h00;
    logic [5:0]  tp = 6'h00;
    logic [7:0]  pul = 8'h00, en = 8'h00, clr = 8'h00, pend, ev, q[$];
    logic [15:0] seed = 16'h0041;
    int          bad_count = 0, cmp_count = 0;
    elp_top dut (.clock(clock), .rst(rst), .bus_role_select(role), .load_req_n(req_n),
        .all_done_n(done_n), .load_start(start), .load_finished(fin), .load_ok(ok),
        .mgmt_reset(mrst), .event_pulse(pul), .event_enable(en), .event_clear(clr),
        .event_pending(pend), .irq_n_out(od), .irq_n_oe(oe), .factory_test_in_a(tp[0]),
        .factory_test_in_b(tp[1]), .factory_test_in_c(tp[2]), .factory_test_in_d(tp[3]),
        .factory_test_in_e(tp[4]), .factory_test_in_f(tp[5]));
    elp_eeprom_model eep (.clock(clock), .rst(rst), .load_start(start), .fail(fail),
        .dly(dly), .load_finished(fin), .load_ok(ok));
    always #50 clock = ~clock;
    // Start pulses are counted so that a second load shows in every note.
    always @(posedge clock) if (start === 1'b1) starts <= starts + 5'h01;
    always @(negedge clock) while (q.size() > 0) begin
        ev = q.pop_front();
        `CHK({done_n, mrst, oe, starts}, ev)
    end
    function automatic logic [15:0] xs(input logic [15:0] s);
        s ^= s << 7;
        s ^= s >> 9;
        return s ^ (s << 8);
    endfunction
    // Test pins get fresh random levels at the end of each step call; they must change nothing.
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
        seed = xs(seed);
        tp = seed[5:0];
    endtask
    task automatic note(input logic [2:0] o, input string s);
        q.push_back({o, nst});
        step(1);
        $display("test %s ended", s);
    endtask
    task automatic restart(input logic [1:0] r);
        rst = 1'b1;
        role = r;
        req_n = 1'b1;
        step(4);
        rst = 1'b0;
        step(1);
    endtask
    // Bounded wait for the engine answer or for completion.
    task automatic wait_for(input logic on_fin);
        int i;
        for (i = 0; i < 40 && (on_fin ? fin !== 1'b1 : done_n !== 1'b0); i++) step(1);
        if (i == 40) begin bad_count++; conclude(); end
    endtask
    task automatic conclude;
        $display("compared %0d, failed %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        restart(elp_pkg::ELP_ROLE_MASTER);
        note(3'b100, "reset");
        req_n = 1'b0;
        nst++;
        wait_for(1'b0);
        step(10);
        note(3'b000, "load held low");
        restart(elp_pkg::ELP_ROLE_MASTER);
        fail = 1'b1;
        req_n = 1'b0;
        nst++;
        wait_for(1'b1);
        step(3);
        note(3'b100, "failed load");
        req_n = 1'b1;
        fail = 1'b0;
        step(2);
        req_n = 1'b0;
        nst++;
        wait_for(1'b0);
        note(3'b000, "retry");
        restart(elp_pkg::ELP_ROLE_MASTER);
        dly = 4'hA;
        req_n = 1'b0;
        nst++;
        step(3);
        req_n = 1'b1;
        step(15);
        note(3'b100, "aborted load");
        for (int i = 0; i < 8; i++) begin
            en = 8'h01 << i;
            step(1);
            pul = seed[15:8] | (i[0] ? 8'h00 : en);
            step(1);
            ev = pul;
            pul = 8'h00;
            note({2'b10, ev[i]}, "masked event");
            clr = 8'hFF;
            step(1);
            clr = 8'h00;
            step(1);
            note(3'b100, "cleared event");
        end
        restart(elp_pkg::ELP_ROLE_SLAVE);
        en = 8'h01;
        pul = 8'h01;
        step(1);
        pul = 8'h00;
        step(1);
        note(3'b101, "slave irq");
        req_n = 1'b0;
        step(4);
        note(3'b010, "slave reset");
        req_n = 1'b1;
        step(2);
        note(3'b100, "slave run");
        conclude();
    end
endmodule // elp_top_tb
`default_nettype wire
